// ### src/mfr_host_ram_access.sv
// apb register block giving host access to mac fifo rams and drop config
`timescale 1ns/1ps
// Function
// RL1: flow-control select high means half-duplex backpressure, low means pause frames.
// RL2: read-only receive-full flag sets when receive storage reaches capacity.
// RL3: clear bit high clears full flag; flag works again only after clear released.
// RL4: width bit, reset one, selects byte per clock else nibble per clock.
// RL5: short-drop bit set discards received frames shorter than 64 bytes.
// RL6: set mask bit ignores vector bit; cleared bit compares against match level.
// RL7: software raises tx write request only with ack low and path idle.
// RL8: tx write ack rises after request rises, falls after it falls; read-only.
// RL9: tx write stores 40-bit word, high byte from field 23:16, low from next register.
// RL10: tx control byte holds control, pad mode, override, crc, end, invalid count.
// RL11: tx write mode bit low addresses ram; high loads fabric-side write pointer.
// RL12: reading tx write address returns fabric-side write pointer in bits 11:0.
// RL13: address fields sized from ram address width; mode bits stay left-justified.
// RL14: software raises tx read request only with ack low and path steady.
// RL15: tx read ack rises after data returned, falls after request falls; read-only.
// RL16: tx read mode low reads ram location; high returns system-side read pointer.
// RL17: tx read data is read-only: control byte in 23:16, low word separately.
// RL18: software raises rx write request only with ack low and path steady.
// RL19: rx write ack follows request rise and fall after data accepted.
// RL20: rx word bits 39:36 unused, 35 start, 34 end; mode bit 13 low writes ram.
// RL21: rx word bits 33:32 carry invalid byte count of the final word.
// RL22: short frames aside, frame dropped only when every unmasked vector bit equals its match level.
module mfr_host_ram_access
  import mfr_pkg::*;
(
  input wire logic clock,
  input wire logic arst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic flow_half_duplex_en,
  output logic flow_pause_en,
  output logic byte_mode,
  input wire logic rx_store_at_capacity,
  output logic rx_full,
  input wire logic rx_stat_valid,
  input wire logic [VEC_W-1:0] rx_stat_vec,
  input wire logic [LEN_W-1:0] rx_frame_len,
  output logic rx_frame_drop,
  output logic tx_ram_we,
  output logic [TX_AW-1:0] tx_ram_waddr,
  output logic [WORD_W-1:0] tx_ram_wdata,
  output logic tx_ram_re,
  output logic [TX_AW-1:0] tx_ram_raddr,
  input wire logic [WORD_W-1:0] tx_ram_rdata,
  output logic tx_fifo_fabric_side_wptr_load,
  output logic [TX_PW-1:0] tx_fifo_fabric_side_wptr_val,
  input wire logic [TX_PW-1:0] tx_fifo_fabric_side_wptr,
  input wire logic [TX_PW-1:0] tx_fifo_system_side_rptr,
  output logic rx_ram_we,
  output logic [RX_AW-1:0] rx_ram_waddr,
  output logic [WORD_W-1:0] rx_ram_wdata,
  output logic rx_fifo_system_side_wptr_load,
  output logic [RX_PW-1:0] rx_fifo_system_side_wptr_val,
  input wire logic [RX_PW-1:0] rx_fifo_system_side_wptr
);

  typedef struct packed {
    logic hdplx;
    logic srfull;
    logic fullclr;
    logic bytmode;
    logic drop_short;
    logic [VEC_W-1:0] dc_mask;
    logic [VEC_W-1:0] match;
    logic twreq;
    logic twack;
    logic [7:0] twhi;
    logic [TX_ADX_W-1:0] twadx;
    logic [31:0] twlo;
    logic trreq;
    logic track;
    logic trpend;
    logic [TX_ADX_W-1:0] tradx;
    logic [7:0] trhi;
    logic [31:0] trlo;
    logic [TX_PW-1:0] trptr;
    logic rwreq;
    logic rwack;
    logic [7:0] rwhi;
    logic [RX_ADX_W-1:0] rwadx;
    logic [31:0] rwlo;
    logic [31:0] rdata;
    logic slverr;
    logic tx_we;
    logic tx_re;
    logic tx_load;
    logic rx_we;
    logic rx_load;
    logic drop;
  } mfr_state_t;

  mfr_state_t s_r;
  mfr_state_t s_nxt;

  logic setup;
  logic access_wr;
  logic mapped;
  logic [31:0] rd_mux;
  logic vec_match;
  logic any_unmasked;

  assign setup = psel && !penable;
  assign access_wr = psel && penable && pwrite;
  assign pready = 1'b1;

  always_comb begin
    mapped = 1'b1;
    rd_mux = 32'h0000_0000;
    unique case (paddr)
      OFF_DROP_MATCH: rd_mux = {14'h0000, s_r.match};
      OFF_FLOW_DROP_CFG: rd_mux = {9'h000, s_r.hdplx, s_r.srfull, s_r.fullclr, s_r.bytmode,
                                   s_r.drop_short, s_r.dc_mask};
      // live fabric-side write pointer readback
      OFF_TX_WR_CTRL: rd_mux = {s_r.twreq, s_r.twack, 6'h00, s_r.twhi, 3'h0,
                                s_r.twadx[TX_MODE_BIT], tx_fifo_fabric_side_wptr}; // RL12 RL13
      OFF_TX_WR_LO: rd_mux = s_r.twlo;
      OFF_TX_RD_CTRL: rd_mux = {s_r.trreq, s_r.track, 6'h00, s_r.trhi, 3'h0,
                                s_r.tradx[TX_MODE_BIT],
                                s_r.tradx[TX_MODE_BIT] ? s_r.trptr
                                                       : s_r.tradx[TX_PW-1:0]}; // RL16 RL17
      OFF_TX_RD_LO: rd_mux = s_r.trlo; // RL17
      OFF_RX_WR_CTRL: rd_mux = {s_r.rwreq, s_r.rwack, 6'h00, s_r.rwhi, 2'h0,
                                s_r.rwadx[RX_MODE_BIT], rx_fifo_system_side_wptr};
      OFF_RX_WR_LO: rd_mux = s_r.rwlo;
      default: mapped = 1'b0;
    endcase
  end

  // drop check over unmasked statistics bits
  assign vec_match = &(~(rx_stat_vec ^ s_r.match) | s_r.dc_mask); // RL6 RL22
  assign any_unmasked = |(~s_r.dc_mask);

  always_comb begin
    s_nxt = s_r;
    s_nxt.tx_we = 1'b0;
    s_nxt.tx_re = 1'b0;
    s_nxt.tx_load = 1'b0;
    s_nxt.rx_we = 1'b0;
    s_nxt.rx_load = 1'b0;
    s_nxt.drop = 1'b0;
    // apb read data and error captured in the setup cycle
    if (setup) begin
      s_nxt.rdata = pwrite ? 32'h0000_0000 : rd_mux;
      s_nxt.slverr = !mapped;
    end
    if (access_wr && mapped) begin
      unique case (paddr)
        OFF_DROP_MATCH: s_nxt.match = pwdata[VEC_W-1:0];
        OFF_FLOW_DROP_CFG: begin
          s_nxt.hdplx = pwdata[B_HDPLX];
          s_nxt.fullclr = pwdata[B_FULLCLR];
          s_nxt.bytmode = pwdata[B_BYTMODE];
          s_nxt.drop_short = pwdata[B_DROP_SHORT];
          s_nxt.dc_mask = pwdata[VEC_W-1:0];
        end
        // ack bit is not writable
        OFF_TX_WR_CTRL: begin
          s_nxt.twreq = pwdata[B_REQ]; // RL8
          s_nxt.twhi = pwdata[B_HI_LSB +: 8]; // RL9 RL10
          s_nxt.twadx = pwdata[TX_ADX_W-1:0]; // RL13
        end
        OFF_TX_WR_LO: s_nxt.twlo = pwdata; // RL9
        OFF_TX_RD_CTRL: begin
          s_nxt.trreq = pwdata[B_REQ]; // RL15
          s_nxt.tradx = pwdata[TX_ADX_W-1:0];
        end
        OFF_RX_WR_CTRL: begin
          s_nxt.rwreq = pwdata[B_REQ];
          s_nxt.rwhi = pwdata[B_HI_LSB +: 8];
          s_nxt.rwadx = pwdata[RX_ADX_W-1:0];
        end
        OFF_RX_WR_LO: s_nxt.rwlo = pwdata;
        default: s_nxt.slverr = s_r.slverr;
      endcase
    end
    // receive full flag, held clear while the clear bit stands
    if (s_r.fullclr) begin
      s_nxt.srfull = 1'b0; // RL3
    end else if (rx_store_at_capacity) begin
      s_nxt.srfull = 1'b1; // RL2
    end
    // tx ram write handshake
    if (s_r.twreq && !s_r.twack) begin
      s_nxt.twack = 1'b1; // RL8
      if (!s_r.twadx[TX_MODE_BIT]) begin
        s_nxt.tx_we = 1'b1; // RL11
      end else begin
        s_nxt.tx_load = 1'b1; // RL11
      end
    end else if (!s_r.twreq && s_r.twack) begin
      s_nxt.twack = 1'b0; // RL8
    end
    // tx ram read handshake, one cycle ram latency
    if (s_r.trreq && !s_r.track && !s_r.trpend) begin
      if (!s_r.tradx[TX_MODE_BIT]) begin
        s_nxt.tx_re = 1'b1; // RL16
        s_nxt.trpend = 1'b1;
      end else begin
        s_nxt.trptr = tx_fifo_system_side_rptr; // RL16
        s_nxt.track = 1'b1; // RL15
      end
    end else if (s_r.trpend && !s_r.tx_re) begin
      s_nxt.trhi = tx_ram_rdata[WORD_W-1:32]; // RL17
      s_nxt.trlo = tx_ram_rdata[31:0]; // RL17
      s_nxt.trpend = 1'b0;
      s_nxt.track = 1'b1; // RL15
    end else if (!s_r.trreq && s_r.track) begin
      s_nxt.track = 1'b0; // RL15
    end
    // rx ram write handshake
    if (s_r.rwreq && !s_r.rwack) begin
      s_nxt.rwack = 1'b1; // RL19
      if (!s_r.rwadx[RX_MODE_BIT]) begin
        s_nxt.rx_we = 1'b1; // RL20
      end else begin
        s_nxt.rx_load = 1'b1;
      end
    end else if (!s_r.rwreq && s_r.rwack) begin
      s_nxt.rwack = 1'b0; // RL19
    end
    // frame drop decision
    if (rx_stat_valid) begin
      s_nxt.drop = (any_unmasked && vec_match) ||
                   (s_r.drop_short && (rx_frame_len < MIN_FRAME_LEN)); // RL5 RL6 RL22
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      s_r <= '0;
      s_r.bytmode <= RST_BYTMODE; // RL4
      s_r.dc_mask <= RST_DC_MASK; // RL6
      s_r.match <= RST_MATCH;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign prdata = s_r.rdata;
  assign pslverr = s_r.slverr;
  assign flow_half_duplex_en = s_r.hdplx; // RL1
  assign flow_pause_en = !s_r.hdplx; // RL1
  assign byte_mode = s_r.bytmode; // RL4
  assign rx_full = s_r.srfull;
  assign rx_frame_drop = s_r.drop;
  assign tx_ram_we = s_r.tx_we;
  assign tx_ram_waddr = s_r.twadx[TX_AW-1:0];
  assign tx_ram_wdata = {s_r.twhi, s_r.twlo}; // RL9 RL10
  assign tx_ram_re = s_r.tx_re;
  assign tx_ram_raddr = s_r.tradx[TX_AW-1:0];
  assign tx_fifo_fabric_side_wptr_load = s_r.tx_load;
  assign tx_fifo_fabric_side_wptr_val = s_r.twadx[TX_PW-1:0]; // RL11
  assign rx_ram_we = s_r.rx_we;
  assign rx_ram_waddr = s_r.rwadx[RX_AW-1:0];
  assign rx_ram_wdata = {4'h0, s_r.rwhi[3:0], s_r.rwlo}; // RL20 RL21
  assign rx_fifo_system_side_wptr_load = s_r.rx_load;
  assign rx_fifo_system_side_wptr_val = s_r.rwadx[RX_PW-1:0];

  property p_flow_sel;
    @(posedge clock) disable iff (!arst_n)
      (access_wr && paddr == OFF_FLOW_DROP_CFG) |=>
        flow_half_duplex_en == $past(pwdata[B_HDPLX]) &&
        flow_pause_en != flow_half_duplex_en;
  endproperty
  a_flow_sel: assert property (p_flow_sel) else $error("flow select outputs disagree"); // RL1

  property p_full_set;
    @(posedge clock) disable iff (!arst_n)
      (rx_store_at_capacity && !s_r.fullclr) |=> rx_full;
  endproperty
  a_full_set: assert property (p_full_set) else $error("full flag not set"); // RL2

  property p_full_clr;
    @(posedge clock) disable iff (!arst_n)
      s_r.fullclr |=> !rx_full;
  endproperty
  a_full_clr: assert property (p_full_clr) else $error("full flag set during clear"); // RL3

  property p_twack_rise;
    @(posedge clock) disable iff (!arst_n)
      $rose(s_r.twack) |-> $past(s_r.twreq) && (tx_ram_we || tx_fifo_fabric_side_wptr_load);
  endproperty
  a_twack_rise: assert property (p_twack_rise) else $error("tx write ack rose wrongly"); // RL8

  property p_twack_fall;
    @(posedge clock) disable iff (!arst_n)
      (s_r.twack && !s_r.twreq) |=> !s_r.twack;
  endproperty
  a_twack_fall: assert property (p_twack_fall) else $error("tx write ack did not fall"); // RL8

  property p_tx_we_mode;
    @(posedge clock) disable iff (!arst_n)
      tx_ram_we |-> !s_r.twadx[TX_MODE_BIT] && !tx_fifo_fabric_side_wptr_load;
  endproperty
  a_tx_we_mode: assert property (p_tx_we_mode) else $error("tx ram write in pointer mode"); // RL11

  property p_tx_read;
    @(posedge clock) disable iff (!arst_n)
      tx_ram_re |-> !s_r.track ##1 !s_r.track ##1 s_r.track && s_r.trlo == $past(tx_ram_rdata[31:0]);
  endproperty
  a_tx_read: assert property (p_tx_read) else $error("tx read ack timing wrong"); // RL15

  property p_rx_we;
    @(posedge clock) disable iff (!arst_n)
      (s_r.rwreq && !s_r.rwack && !s_r.rwadx[RX_MODE_BIT]) |=> rx_ram_we && s_r.rwack;
  endproperty
  a_rx_we: assert property (p_rx_we) else $error("rx ram write missing"); // RL19

  property p_short_drop;
    @(posedge clock) disable iff (!arst_n)
      (rx_stat_valid && s_r.drop_short && rx_frame_len < MIN_FRAME_LEN) |=> rx_frame_drop;
  endproperty
  a_short_drop: assert property (p_short_drop) else $error("short frame not dropped"); // RL5

  property p_mask_drop;
    @(posedge clock) disable iff (!arst_n)
      (rx_stat_valid && !s_r.drop_short && s_r.dc_mask == RST_DC_MASK) |=> !rx_frame_drop;
  endproperty
  a_mask_drop: assert property (p_mask_drop) else $error("fully masked vector dropped"); // RL6

  property p_bytmode_wr;
    @(posedge clock) disable iff (!arst_n)
      (access_wr && paddr == OFF_FLOW_DROP_CFG) |=> byte_mode == $past(pwdata[B_BYTMODE]);
  endproperty
  a_bytmode_wr: assert property (p_bytmode_wr) else $error("width select not stored"); // RL4

  property p_twack_hold;
    @(posedge clock) disable iff (!arst_n)
      (s_r.twack && s_r.twreq) |=> s_r.twack;
  endproperty
  a_twack_hold: assert property (p_twack_hold) else $error("tx write ack fell early"); // RL8

  property p_tx_load;
    @(posedge clock) disable iff (!arst_n)
      (s_r.twreq && !s_r.twack && s_r.twadx[TX_MODE_BIT]) |=>
        tx_fifo_fabric_side_wptr_load && !tx_ram_we;
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("tx pointer load missing"); // RL11

  property p_track_rise;
    @(posedge clock) disable iff (!arst_n)
      $rose(s_r.track) |-> $past(s_r.trreq);
  endproperty
  a_track_rise: assert property (p_track_rise) else $error("tx read ack without request"); // RL15

  property p_track_fall;
    @(posedge clock) disable iff (!arst_n)
      (s_r.track && !s_r.trreq) |=> !s_r.track;
  endproperty
  a_track_fall: assert property (p_track_fall) else $error("tx read ack did not fall"); // RL15

  property p_tx_ptr_rd;
    @(posedge clock) disable iff (!arst_n)
      (s_r.trreq && !s_r.track && !s_r.trpend && s_r.tradx[TX_MODE_BIT]) |=>
        s_r.track && !tx_ram_re && s_r.trptr == $past(tx_fifo_system_side_rptr);
  endproperty
  a_tx_ptr_rd: assert property (p_tx_ptr_rd) else $error("tx read pointer not taken"); // RL16

  property p_rwack_fall;
    @(posedge clock) disable iff (!arst_n)
      (s_r.rwack && !s_r.rwreq) |=> !s_r.rwack;
  endproperty
  a_rwack_fall: assert property (p_rwack_fall) else $error("rx write ack did not fall"); // RL19

  property p_match_drop;
    @(posedge clock) disable iff (!arst_n)
      (rx_stat_valid && s_r.dc_mask != RST_DC_MASK &&
       ((rx_stat_vec ^ s_r.match) & ~s_r.dc_mask) == '0) |=> rx_frame_drop;
  endproperty
  a_match_drop: assert property (p_match_drop) else $error("matching frame not dropped"); // RL22

  property p_drop_pulse;
    @(posedge clock) disable iff (!arst_n)
      rx_frame_drop |-> $past(rx_stat_valid);
  endproperty
  a_drop_pulse: assert property (p_drop_pulse) else $error("drop without statistics"); // RL5

endmodule // mfr_host_ram_access

// ### shared/mfr_pkg.sv
// constants for the mac fifo host ram access block
package mfr_pkg;
  // clock
  localparam int CLK_HZ = 50000000;
  // ram geometry
  localparam int TX_AW = 11;
  localparam int RX_AW = 12;
  localparam int TX_PW = TX_AW + 1;
  localparam int RX_PW = RX_AW + 1;
  localparam int TX_ADX_W = TX_AW + 2;
  localparam int RX_ADX_W = RX_AW + 2;
  localparam int TX_MODE_BIT = TX_AW + 1;
  localparam int RX_MODE_BIT = RX_AW + 1;
  localparam int WORD_W = 40;
  localparam int VEC_W = 18;
  localparam int LEN_W = 16;
  // register byte offsets
  localparam logic [11:0] OFF_DROP_MATCH = 12'h058;
  localparam logic [11:0] OFF_FLOW_DROP_CFG = 12'h05C;
  localparam logic [11:0] OFF_TX_WR_CTRL = 12'h060;
  localparam logic [11:0] OFF_TX_WR_LO = 12'h064;
  localparam logic [11:0] OFF_TX_RD_CTRL = 12'h068;
  localparam logic [11:0] OFF_TX_RD_LO = 12'h06C;
  localparam logic [11:0] OFF_RX_WR_CTRL = 12'h070;
  localparam logic [11:0] OFF_RX_WR_LO = 12'h074;
  // field positions
  localparam int B_HDPLX = 22;
  localparam int B_SRFULL = 21;
  localparam int B_FULLCLR = 20;
  localparam int B_BYTMODE = 19;
  localparam int B_DROP_SHORT = 18;
  localparam int B_REQ = 31;
  localparam int B_ACK = 30;
  localparam int B_HI_LSB = 16;
  // reset values
  localparam logic RST_BYTMODE = 1'b1;
  localparam logic [VEC_W-1:0] RST_DC_MASK = 18'h3FFFF;
  localparam logic [VEC_W-1:0] RST_MATCH = 18'h00000;
  // short frame limit in bytes
  localparam logic [LEN_W-1:0] MIN_FRAME_LEN = 16'h0040;
endpackage

// ### tb/tb.sv
// self-checking testbench for the mac fifo host ram access block
`timescale 1ns/1ps
module tb;
  import mfr_pkg::*;
  logic clock, arst_n, psel, penable, pwrite, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic fhd, fpe, bm, cap, rfull, sv, drop, twe, tre, tpl, rwe, rpl;
  logic [VEC_W-1:0] vec;
  logic [LEN_W-1:0] len;
  logic [TX_AW-1:0] twa, tra;
  logic [RX_AW-1:0] rwa;
  logic [WORD_W-1:0] twd, rwd;
  logic [WORD_W-1:0] trd = '0;
  logic [TX_PW-1:0] tpv, fwp, srp;
  logic [RX_PW-1:0] rpv, rwp;
  logic [63:0] cap_tw, cap_tr, cap_tp, cap_rw, cap_rp;
  int num_errors = 0, check_count = 0, n_tw = 0, n_tr = 0, n_rw = 0;

  mfr_host_ram_access u_mfr_host_ram_access (.clock(clock), .arst_n(arst_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .flow_half_duplex_en(fhd), .flow_pause_en(fpe),
    .byte_mode(bm), .rx_store_at_capacity(cap), .rx_full(rfull), .rx_stat_valid(sv),
    .rx_stat_vec(vec), .rx_frame_len(len), .rx_frame_drop(drop), .tx_ram_we(twe),
    .tx_ram_waddr(twa), .tx_ram_wdata(twd), .tx_ram_re(tre), .tx_ram_raddr(tra),
    .tx_ram_rdata(trd), .tx_fifo_fabric_side_wptr_load(tpl),
    .tx_fifo_fabric_side_wptr_val(tpv), .tx_fifo_fabric_side_wptr(fwp),
    .tx_fifo_system_side_rptr(srp), .rx_ram_we(rwe), .rx_ram_waddr(rwa),
    .rx_ram_wdata(rwd), .rx_fifo_system_side_wptr_load(rpl),
    .rx_fifo_system_side_wptr_val(rpv), .rx_fifo_system_side_wptr(rwp));

  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end

  // synchronous ram model and pulse capture
  always @(posedge clock) begin
    trd <= word(tra);
    if (twe === 1'b1) begin n_tw++; cap_tw = {twa, twd}; end
    if (tre === 1'b1) begin n_tr++; cap_tr = tra; end
    if (tpl === 1'b1) cap_tp = tpv;
    if (rwe === 1'b1) begin n_rw++; cap_rw = {rwa, rwd}; end
    if (rpl === 1'b1) cap_rp = rpv;
  end

  function automatic logic [39:0] word(logic [10:0] a);
    return {a[7:0], 10'h000, a, a};
  endfunction

  function automatic logic exp_drop(logic [17:0] m, t, v, logic s, logic [15:0] l);
    return (!(&m) && ~|((v ^ t) & ~m)) || (s && l < MIN_FRAME_LEN);
  endfunction

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic poll(input logic [11:0] a, input int b, input logic v);
    int k = 0;
    do begin apb(1'b0, a, 32'h0); k++; end while (rd[b] !== v && k < 20);
    chk(rd[b], v);
  endtask

  task automatic hs_on(input logic [11:0] a, input logic [31:0] v);
    apb(1'b1, a, v | 32'h80000000);
    poll(a, B_ACK, 1'b1);
  endtask

  task automatic hs_off(input logic [11:0] a, input logic [31:0] v);
    apb(1'b1, a, v | 32'h40000000);
    poll(a, B_ACK, 1'b0);
  endtask

  task automatic test_done();
    if (num_errors == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    #1_000_000;
    num_errors++;
    test_done();
  end

  initial begin
    logic [31:0] cfg, lo;
    logic [17:0] msk, mt;
    logic [7:0] hi;
    logic [12:0] a;
    int i, n0;
    arst_n = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0; paddr = '0; pwdata = '0;
    cap = 1'b0; sv = 1'b0; vec = '0; len = '0;
    i = $urandom(32'h5800);
    fwp = $urandom; srp = $urandom; rwp = $urandom;
    repeat (4) @(posedge clock);
    arst_n <= 1'b1;
    chk({bm, fpe, fhd, rfull, drop, twe, tre, rwe}, 8'hC0);
    apb(1'b0, OFF_FLOW_DROP_CFG, 32'h0);
    chk({err, rd}, {1'b0, 32'h000BFFFF});
    apb(1'b0, 12'h0F0, 32'h0);
    chk({err, rd}, {1'b1, 32'h0});
    for (i = 0; i < 48; i++) begin
      msk = (i % 3 == 0) ? 18'h3FFFF : (i % 3 == 1) ? 18'h00000 : 18'($urandom);
      mt = $urandom;
      cfg = ($urandom & 32'h004C0000) | msk;
      apb(1'b1, OFF_DROP_MATCH, {14'h0, mt});
      apb(1'b1, OFF_FLOW_DROP_CFG, cfg);
      apb(1'b0, OFF_FLOW_DROP_CFG, 32'h0);
      chk(rd, cfg);
      chk({fhd, fpe, bm}, {cfg[22], ~cfg[22], cfg[19]});
      @(posedge clock);
      sv <= 1'b1;
      vec <= i[3] ? 18'($urandom) : i[2] ? mt ^ msk : mt ^ ~msk;
      len <= i[0] ? 16'(62 + $urandom % 3) : 16'($urandom % 200);
      @(posedge clock);
      sv <= 1'b0;
      @(posedge clock);
      chk(drop, exp_drop(msk, mt, vec, cfg[18], len));
    end
    cap <= 1'b1;
    repeat (2) @(posedge clock);
    cap <= 1'b0;
    apb(1'b0, OFF_FLOW_DROP_CFG, 32'h0);
    chk({rd[21], rfull}, 2'b11);
    apb(1'b1, OFF_FLOW_DROP_CFG, cfg | 32'h00300000);
    cap <= 1'b1;
    poll(OFF_FLOW_DROP_CFG, B_SRFULL, 1'b0);
    cap <= 1'b0;
    apb(1'b1, OFF_FLOW_DROP_CFG, cfg);
    apb(1'b0, OFF_FLOW_DROP_CFG, 32'h0);
    chk({rd[21], rfull}, 2'b00);
    cap <= 1'b1;
    apb(1'b0, OFF_FLOW_DROP_CFG, 32'h0);
    cap <= 1'b0;
    apb(1'b0, OFF_FLOW_DROP_CFG, 32'h0);
    chk({rd[21], rfull}, 2'b11);
    repeat (4) begin
      lo = $urandom; hi = $urandom; a = $urandom; n0 = n_tw;
      apb(1'b1, OFF_TX_WR_LO, lo);
      hs_on(OFF_TX_WR_CTRL, {8'h00, hi, 3'h0, 2'b00, a[10:0]});
      hs_off(OFF_TX_WR_CTRL, {8'h00, hi, 3'h0, 2'b00, a[10:0]});
      chk(cap_tw, {a[10:0], hi, lo});
      hs_on(OFF_TX_WR_CTRL, {19'h0, 1'b1, a[11:0]});
      hs_off(OFF_TX_WR_CTRL, {19'h0, 1'b1, a[11:0]});
      chk({n_tw - n0, cap_tp[31:0]}, {32'd1, 32'(a[11:0])});
      apb(1'b0, OFF_TX_WR_CTRL, 32'h0);
      chk(rd[11:0], fwp);
      n0 = n_tr;
      hs_on(OFF_TX_RD_CTRL, {21'h0, a[10:0]});
      apb(1'b0, OFF_TX_RD_CTRL, 32'h0);
      chk(rd[23:16], word(a[10:0]) >> 32);
      apb(1'b1, OFF_TX_RD_LO, ~lo);
      apb(1'b0, OFF_TX_RD_LO, 32'h0);
      chk(rd, word(a[10:0]) & 40'hFFFFFFFF);
      hs_off(OFF_TX_RD_CTRL, {21'h0, a[10:0]});
      chk({n_tr - n0, cap_tr[31:0]}, {32'd1, 32'(a[10:0])});
      hs_on(OFF_TX_RD_CTRL, 32'h00001000);
      apb(1'b0, OFF_TX_RD_CTRL, 32'h0);
      chk(rd[11:0], srp);
      hs_off(OFF_TX_RD_CTRL, 32'h00001000);
      n0 = n_rw;
      apb(1'b1, OFF_RX_WR_LO, lo);
      hs_on(OFF_RX_WR_CTRL, {8'h00, hi, 4'h0, a[11:0]});
      hs_off(OFF_RX_WR_CTRL, {8'h00, hi, 4'h0, a[11:0]});
      chk(cap_rw, {a[11:0], 4'h0, hi[3:0], lo});
      hs_on(OFF_RX_WR_CTRL, {18'h0, 1'b1, a});
      hs_off(OFF_RX_WR_CTRL, {18'h0, 1'b1, a});
      chk({n_rw - n0, cap_rp[31:0]}, {32'd1, 32'(a)});
      apb(1'b0, OFF_RX_WR_CTRL, 32'h0);
      chk(rd[12:0], rwp);
    end
    test_done();
  end
endmodule // tb
